// ### inc/exec_tail_pkg.sv
// Constants, register map and encodings for the instruction execute tail
package exec_tail_pkg;
    // Register byte offsets
    localparam logic [11:0] OFF_CMD      = 12'h000;
    localparam logic [11:0] OFF_ADDR     = 12'h004;
    localparam logic [11:0] OFF_ACC      = 12'h008;
    localparam logic [11:0] OFF_FLAGS    = 12'h00c;
    localparam logic [11:0] OFF_TBL_LOW  = 12'h010;
    localparam logic [11:0] OFF_TBL_HIGH = 12'h014;
    localparam logic [11:0] OFF_TBL_BYTE = 12'h018;
    localparam logic [11:0] OFF_BANK     = 12'h01c;
    localparam int          DMEM_WIN_BIT = 11;
    // Flag and status bit positions
    localparam int FLAG_C      = 0;
    localparam int FLAG_AUX    = 1;
    localparam int FLAG_Z      = 2;
    localparam int FLAG_OVF    = 3;
    localparam int FLAG_SKZ    = 4;
    localparam int FLAG_W      = 5;
    localparam int STATUS_BUSY = 8;
    localparam int STATUS_SKIP = 9;
    // Command word fields
    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_OP_W    = 5;
    localparam int CMD_BIT_LSB = 8;
    localparam int CMD_IMM_LSB = 16;
    // Data constants
    localparam logic [3:0]  BCD_LIMIT    = 4'h9;
    localparam logic [7:0]  BCD_LOW_ADJ  = 8'h06;
    localparam logic [7:0]  BCD_HIGH_ADJ = 8'h60;
    localparam logic [7:0]  ZERO_BYTE    = 8'h00;
    localparam logic [7:0]  ONE_BYTE     = 8'h01;
    localparam logic [4:0]  FLAGS_RESET  = 5'h00;
    localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
    localparam int          HTRANS_ACT   = 1;
    localparam logic        HRESP_OKAY   = 1'b0;

    typedef enum logic [4:0] {
        OP_NSWAP   = 5'b00000, OP_SKZ     = 5'b00001, OP_SKZ_A   = 5'b00010,
        OP_SKZ_BIT = 5'b00011, OP_TAB_CUR = 5'b00100, OP_TAB_LST = 5'b00101,
        OP_ITAB    = 5'b00110, OP_ITAB_LS = 5'b00111, OP_XOR_A   = 5'b01000,
        OP_XOR_M   = 5'b01001, OP_XOR_IMM = 5'b01010, OP_ADC     = 5'b01011,
        OP_ADC_M   = 5'b01100, OP_ADD     = 5'b01101, OP_ADD_M   = 5'b01110,
        OP_AND     = 5'b01111, OP_AND_M   = 5'b10000, OP_CLR     = 5'b10001,
        OP_CLR_BIT = 5'b10010, OP_CPL     = 5'b10011, OP_CPL_A   = 5'b10100,
        OP_DAA     = 5'b10101, OP_DEC     = 5'b10110, OP_DEC_A   = 5'b10111,
        OP_INC     = 5'b11000, OP_INC_A   = 5'b11001, OP_MOV_AM  = 5'b11010,
        OP_MOV_MA  = 5'b11011, OP_NOP     = 5'b11111
    } op_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_EXEC  = 3'b001,
        ST_TREAD = 3'b010,
        ST_TWAIT = 3'b011,
        ST_DUMMY = 3'b100
    } state_t;
endpackage

// ### hdl/exec_tail.sv
// Execute unit for swap, skip, table read, XOR and extended instructions
// Operation
// - Swap nibbles of byte into accumulator
// - Skip next when addressed byte is zero
// - Taken skip adds one dummy instruction cycle
// - Copy byte to accumulator, skip if zero
// - Skip next when selected bit is zero
// - Table read in current page via pointer
// - Table read in last program page
// - Increment pointer low, read full pointer
// - Increment pointer low, read last page
// - Table reads change no flags
// - XOR to accumulator or memory, zero flag
// - Extended forms address any memory section
// - Add with carry, five flags updated
// - Add without carry, five flags updated
// - AND to accumulator or memory, zero flag
// - Clear whole byte, no flags
// - Clear one selected bit, no flags
// - Complement to memory or accumulator, zero flag
// - Decimal adjust accumulator into memory
// - Decimal adjust touches only carry
// - Decrement to memory or accumulator, zero flag
// - Increment to memory or accumulator, zero flag
// - Move byte either way, no flags
//
// Decided for this implementation: the address map and the AHB-Lite register port.
`timescale 1ns/1ns
module exec_tail #(
    parameter int DMEM_AW = 9,
    parameter int PROG_AW = 12
) (
    // Clock and reset
    input  wire logic               i_clock,
    input  wire logic               i_reset,
    // AHB-Lite slave
    input  wire logic               i_hsel,
    input  wire logic [31:0]        i_haddr,
    input  wire logic [1:0]         i_htrans,
    input  wire logic               i_hwrite,
    input  wire logic [2:0]         i_hsize,
    input  wire logic [31:0]        i_hwdata,
    input  wire logic               i_hready,
    output logic                    o_hreadyout,
    output logic                    o_hresp,
    output logic [31:0]             o_hrdata,
    // Program memory read port, data one cycle after request
    input  wire logic [PROG_AW-9:0] i_current_page,
    output logic [PROG_AW-1:0]      o_prog_addr,
    output logic                    o_prog_rd,
    input  wire logic [15:0]        i_prog_data,
    // Instruction cycle status
    output logic                    o_dummy_cycle,
    output logic                    o_instr_done
);
    import exec_tail_pkg::*;

    localparam logic [PROG_AW-9:0] LAST_PAGE = '1;
    localparam int                 SEC_W     = DMEM_AW - 8;

    state_t             state_q;
    op_t                op_q;
    logic [2:0]         bit_q;
    logic [7:0]         imm_q;
    logic [DMEM_AW-1:0] addr_q;
    logic [SEC_W-1:0]   bank_q;
    logic [7:0]         acc_q;
    logic [4:0]         flags_q;
    logic [7:0]         tp_lo_q;
    logic [7:0]         tp_hi_q;
    logic [7:0]         tword_hi_q;
    logic [7:0]         tp_lo_next;
    logic               skip_q;
    logic               done_q;
    logic [7:0]         dmem [2**DMEM_AW];

    // Bus pipeline state
    logic               dph_q;
    logic               dwr_q;
    logic [11:0]        daddr_q;
    logic               rd_ok_q;
    logic [31:0]        rdata_q;
    logic               busy;
    logic               accept;
    logic               bus_wr;
    logic               bus_rd;
    logic               dmem_sel;
    logic [31:0]        rd_mux;

    // Execute datapath
    logic               is_ext;
    logic [DMEM_AW-1:0] eaddr;
    logic [7:0]         m;
    logic [7:0]         res;
    logic               wr_mem;
    logic               wr_acc;
    logic               skip;
    logic               is_table;
    logic [4:0]         flags_d;
    logic [8:0]         sum;
    logic [4:0]         low_sum;
    logic [8:0]         daa_t;
    logic [8:0]         daa_r;
    logic               cmd_go;

    assign busy     = (state_q != ST_IDLE);
    assign accept   = i_hsel && i_htrans[HTRANS_ACT] && i_hready;
    assign bus_wr   = dph_q && dwr_q && !busy;
    assign bus_rd   = dph_q && !dwr_q && !busy && !rd_ok_q;
    assign dmem_sel = daddr_q[DMEM_WIN_BIT];
    // Stall the data phase while an instruction runs; reads take one wait for registered data
    assign o_hreadyout = !(dph_q && (busy || (!dwr_q && !rd_ok_q)));
    assign o_hresp     = HRESP_OKAY;
    assign o_hrdata    = rdata_q;
    assign cmd_go      = bus_wr && !dmem_sel && (daddr_q == OFF_CMD);

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            dph_q   <= 1'b0;
            dwr_q   <= 1'b0;
            daddr_q <= OFF_CMD;
        end else if (i_hready) begin
            dph_q   <= accept;
            dwr_q   <= i_hwrite;
            daddr_q <= i_haddr[11:0];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            rd_ok_q <= 1'b0;
            rdata_q <= ZERO_WORD;
        end else begin
            rd_ok_q <= bus_rd;
            if (bus_rd) begin
                rdata_q <= rd_mux;
            end
        end
    end

    always_comb begin
        rd_mux = ZERO_WORD;
        if (dmem_sel) begin
            rd_mux[7:0] = dmem[daddr_q[DMEM_AW+1:2]];
        end else begin
            case (daddr_q)
                OFF_CMD: begin
                    rd_mux[CMD_OP_LSB +: CMD_OP_W] = op_q;
                    rd_mux[CMD_BIT_LSB +: 3]       = bit_q;
                    rd_mux[CMD_IMM_LSB +: 8]       = imm_q;
                end
                OFF_ADDR:     rd_mux[DMEM_AW-1:0] = addr_q;
                OFF_ACC:      rd_mux[7:0]         = acc_q;
                OFF_FLAGS: begin
                    rd_mux[FLAG_W-1:0]  = flags_q;
                    rd_mux[STATUS_BUSY] = busy;
                    rd_mux[STATUS_SKIP] = skip_q;
                end
                OFF_TBL_LOW:  rd_mux[7:0]         = tp_lo_q;
                OFF_TBL_HIGH: rd_mux[7:0]         = tp_hi_q;
                OFF_TBL_BYTE: rd_mux[7:0]         = tword_hi_q;
                OFF_BANK:     rd_mux[SEC_W-1:0]   = bank_q;
                default:      rd_mux              = ZERO_WORD;
            endcase
        end
    end

    // Plain forms reach only the selected section; extended forms take the full address
    assign is_ext = (op_q >= OP_ADC) && (op_q != OP_NOP);
    assign eaddr  = is_ext ? addr_q : {bank_q, addr_q[7:0]};
    assign m      = dmem[eaddr];
    assign tp_lo_next = tp_lo_q + ONE_BYTE;
    assign is_table = (op_q == OP_TAB_CUR) || (op_q == OP_TAB_LST) ||
                      (op_q == OP_ITAB) || (op_q == OP_ITAB_LS);

    always_comb begin
        res     = ZERO_BYTE;
        wr_mem  = 1'b0;
        wr_acc  = 1'b0;
        skip    = 1'b0;
        flags_d = flags_q;
        sum     = {1'b0, acc_q} + {1'b0, m};
        low_sum = {1'b0, acc_q[3:0]} + {1'b0, m[3:0]};
        daa_t   = {1'b0, acc_q};
        daa_r   = {1'b0, acc_q};
        case (op_q)
            OP_NSWAP: begin
                res    = {m[3:0], m[7:4]};
                wr_acc = 1'b1;
            end
            OP_SKZ:     skip = (m == ZERO_BYTE);
            OP_SKZ_A: begin
                res    = m;
                wr_acc = 1'b1;
                skip   = (m == ZERO_BYTE);
            end
            OP_SKZ_BIT: skip = !m[bit_q];
            OP_XOR_A, OP_XOR_M, OP_XOR_IMM: begin
                res    = acc_q ^ ((op_q == OP_XOR_IMM) ? imm_q : m);
                wr_acc = (op_q != OP_XOR_M);
                wr_mem = (op_q == OP_XOR_M);
                flags_d[FLAG_Z] = (res == ZERO_BYTE);
            end
            OP_ADC, OP_ADC_M, OP_ADD, OP_ADD_M: begin
                if (op_q == OP_ADC || op_q == OP_ADC_M) begin
                    sum     = {1'b0, acc_q} + {1'b0, m} + {8'h00, flags_q[FLAG_C]};
                    low_sum = {1'b0, acc_q[3:0]} + {1'b0, m[3:0]} + {4'h0, flags_q[FLAG_C]};
                end
                res    = sum[7:0];
                wr_acc = (op_q == OP_ADC) || (op_q == OP_ADD);
                wr_mem = !wr_acc;
                flags_d[FLAG_C]  = sum[8];
                flags_d[FLAG_AUX] = low_sum[4];
                flags_d[FLAG_OVF] = (acc_q[7] == m[7]) && (sum[7] != acc_q[7]);
                flags_d[FLAG_Z]   = (sum[7:0] == ZERO_BYTE);
                flags_d[FLAG_SKZ] = flags_d[FLAG_OVF] ^ sum[7];
            end
            OP_AND, OP_AND_M: begin
                res    = acc_q & m;
                wr_acc = (op_q == OP_AND);
                wr_mem = (op_q == OP_AND_M);
                flags_d[FLAG_Z] = (res == ZERO_BYTE);
            end
            OP_CLR: begin
                res    = ZERO_BYTE;
                wr_mem = 1'b1;
            end
            OP_CLR_BIT: begin
                res    = m & ~(ONE_BYTE << bit_q);
                wr_mem = 1'b1;
            end
            OP_CPL, OP_CPL_A: begin
                res    = ~m;
                wr_acc = (op_q == OP_CPL_A);
                wr_mem = (op_q == OP_CPL);
                flags_d[FLAG_Z] = (res == ZERO_BYTE);
            end
            OP_DAA: begin
                if ((acc_q[3:0] > BCD_LIMIT) || flags_q[FLAG_AUX]) begin
                    daa_t = {1'b0, acc_q} + {1'b0, BCD_LOW_ADJ};
                end
                daa_r = daa_t;
                if ((daa_t[7:4] > BCD_LIMIT) || flags_q[FLAG_C] || daa_t[8]) begin
                    daa_r = {1'b0, daa_t[7:0]} + {1'b0, BCD_HIGH_ADJ};
                end
                res    = daa_r[7:0];
                wr_mem = 1'b1;
                // Carry only ever rises so a chained decimal sum keeps its overflow
                flags_d[FLAG_C] = flags_q[FLAG_C] | daa_t[8] | daa_r[8];
            end
            OP_DEC, OP_DEC_A, OP_INC, OP_INC_A: begin
                res    = (op_q == OP_DEC || op_q == OP_DEC_A) ? m - ONE_BYTE
                                                              : m + ONE_BYTE;
                wr_acc = (op_q == OP_DEC_A) || (op_q == OP_INC_A);
                wr_mem = !wr_acc;
                flags_d[FLAG_Z] = (res == ZERO_BYTE);
            end
            OP_MOV_AM: begin
                res    = m;
                wr_acc = 1'b1;
            end
            OP_MOV_MA: begin
                res    = acc_q;
                wr_mem = 1'b1;
            end
            default: res = ZERO_BYTE;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE:  state_q <= cmd_go ? ST_EXEC : ST_IDLE;
                ST_EXEC:  state_q <= is_table ? ST_TREAD : (skip ? ST_DUMMY : ST_IDLE);
                ST_TREAD: state_q <= ST_TWAIT;
                ST_TWAIT: state_q <= ST_IDLE;
                ST_DUMMY: state_q <= ST_IDLE;
                default:  state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            op_q   <= OP_NOP;
            bit_q  <= 3'h0;
            imm_q  <= ZERO_BYTE;
            addr_q <= '0;
            bank_q <= '0;
        end else if (bus_wr && !dmem_sel) begin
            case (daddr_q)
                OFF_CMD: begin
                    op_q  <= op_t'(i_hwdata[CMD_OP_LSB +: CMD_OP_W]);
                    bit_q <= i_hwdata[CMD_BIT_LSB +: 3];
                    imm_q <= i_hwdata[CMD_IMM_LSB +: 8];
                end
                OFF_ADDR: addr_q <= i_hwdata[DMEM_AW-1:0];
                OFF_BANK: bank_q <= i_hwdata[SEC_W-1:0];
                default:  addr_q <= addr_q;
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            acc_q <= ZERO_BYTE;
        end else if (state_q == ST_EXEC && wr_acc) begin
            acc_q <= res;
        end else if (bus_wr && !dmem_sel && daddr_q == OFF_ACC) begin
            acc_q <= i_hwdata[7:0];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            flags_q <= FLAGS_RESET;
        end else if (state_q == ST_EXEC && !is_table) begin
            flags_q <= flags_d;
        end else if (bus_wr && !dmem_sel && daddr_q == OFF_FLAGS) begin
            flags_q <= i_hwdata[FLAG_W-1:0];
        end
    end

    // Data memory has no reset; software loads it through the window
    always_ff @(posedge i_clock) begin
        if (state_q == ST_EXEC && wr_mem) begin
            dmem[eaddr] <= res;
        end else if (state_q == ST_TWAIT) begin
            dmem[eaddr] <= i_prog_data[7:0];
        end else if (bus_wr && dmem_sel) begin
            dmem[daddr_q[DMEM_AW+1:2]] <= i_hwdata[7:0];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            tp_lo_q    <= ZERO_BYTE;
            tp_hi_q    <= ZERO_BYTE;
            tword_hi_q <= ZERO_BYTE;
        end else if (state_q == ST_EXEC && (op_q == OP_ITAB || op_q == OP_ITAB_LS)) begin
            tp_lo_q <= tp_lo_next;
        end else if (state_q == ST_TWAIT) begin
            tword_hi_q <= i_prog_data[15:8];
        end else if (bus_wr && !dmem_sel && daddr_q == OFF_TBL_LOW) begin
            tp_lo_q <= i_hwdata[7:0];
        end else if (bus_wr && !dmem_sel && daddr_q == OFF_TBL_HIGH) begin
            tp_hi_q <= i_hwdata[7:0];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_prog_addr <= '0;
            o_prog_rd   <= 1'b0;
        end else begin
            o_prog_rd <= (state_q == ST_EXEC) && is_table;
            // Inc forms must read with the pointer they write back on this same edge
            if (state_q == ST_EXEC) begin
                case (op_q)
                    OP_TAB_CUR: o_prog_addr <= {i_current_page, tp_lo_q};
                    OP_TAB_LST: o_prog_addr <= {LAST_PAGE, tp_lo_q};
                    OP_ITAB:    o_prog_addr <= {tp_hi_q[PROG_AW-9:0], tp_lo_next};
                    OP_ITAB_LS: o_prog_addr <= {LAST_PAGE, tp_lo_next};
                    default:    o_prog_addr <= o_prog_addr;
                endcase
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            skip_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            if (cmd_go) begin
                skip_q <= 1'b0;
            end else if (state_q == ST_EXEC) begin
                skip_q <= skip;
            end
            done_q <= (state_q == ST_EXEC && !is_table && !skip) ||
                      state_q == ST_TWAIT || state_q == ST_DUMMY;
        end
    end

    assign o_dummy_cycle = (state_q == ST_DUMMY);
    assign o_instr_done  = done_q;

    sequence seq_exec(op_t o);
        state_q == ST_EXEC && op_q == o;
    endsequence

    sequence seq_table_run;
        state_q == ST_TREAD ##1 state_q == ST_TWAIT;
    endsequence

    a_swap_acc: assert property (@(posedge i_clock) disable iff (i_reset)
        seq_exec(OP_NSWAP) |=> acc_q == {$past(m[3:0]), $past(m[7:4])} && $stable(flags_q))
        else $error("swap result wrong");
    a_zero_skip: assert property (@(posedge i_clock) disable iff (i_reset)
        seq_exec(OP_SKZ) |-> ##1 (o_dummy_cycle == ($past(m) == ZERO_BYTE)))
        else $error("zero skip wrong");
    a_skip_dummy: assert property (@(posedge i_clock) disable iff (i_reset)
        (state_q == ST_EXEC && skip) |=> o_dummy_cycle ##1 (state_q == ST_IDLE && o_instr_done))
        else $error("skip cycle wrong");
    a_copy_skip: assert property (@(posedge i_clock) disable iff (i_reset)
        seq_exec(OP_SKZ_A) |=> acc_q == $past(m) && skip_q == (acc_q == ZERO_BYTE))
        else $error("copy skip wrong");
    a_bit_skip: assert property (@(posedge i_clock) disable iff (i_reset)
        seq_exec(OP_SKZ_BIT) |=> skip_q == !$past(m[bit_q]))
        else $error("bit skip wrong");
    a_table_last: assert property (@(posedge i_clock) disable iff (i_reset)
        (state_q == ST_TREAD && op_q == OP_TAB_LST) |-> o_prog_rd &&
            o_prog_addr == {LAST_PAGE, tp_lo_q})
        else $error("last page address wrong");
    a_table_inc: assert property (@(posedge i_clock) disable iff (i_reset)
        seq_exec(OP_ITAB) |=> tp_lo_q == 8'($past(tp_lo_q) + ONE_BYTE) &&
            o_prog_addr == {tp_hi_q[PROG_AW-9:0], tp_lo_q})
        else $error("table increment wrong");
    a_table_flags: assert property (@(posedge i_clock) disable iff (i_reset)
        (state_q == ST_EXEC && is_table) |=> seq_table_run ##1 flags_q == $past(flags_q, 3))
        else $error("table read changed flags");
    a_table_high: assert property (@(posedge i_clock) disable iff (i_reset)
        state_q == ST_TWAIT |=> tword_hi_q == $past(i_prog_data[15:8]))
        else $error("table high byte wrong");
    a_xor_zero: assert property (@(posedge i_clock) disable iff (i_reset)
        seq_exec(OP_XOR_A) |=> acc_q == ($past(acc_q) ^ $past(m)) &&
            flags_q[FLAG_Z] == (acc_q == ZERO_BYTE) && flags_q[FLAG_C] == $past(flags_q[FLAG_C]))
        else $error("xor result wrong");
    a_add_carry: assert property (@(posedge i_clock) disable iff (i_reset)
        seq_exec(OP_ADC) |=> {flags_q[FLAG_C], acc_q} ==
            9'({1'b0, $past(acc_q)} + {1'b0, $past(m)} + {8'h00, $past(flags_q[FLAG_C])}))
        else $error("add with carry wrong");
    a_daa_flags: assert property (@(posedge i_clock) disable iff (i_reset)
        seq_exec(OP_DAA) |=> flags_q[FLAG_W-1:1] == $past(flags_q[FLAG_W-1:1]) && acc_q == $past(acc_q))
        else $error("decimal adjust touched other flags");
endmodule

// ### verification/prog_mem_model.sv
// Program memory model answering table reads one cycle after the strobe
`timescale 1ns/1ns
module prog_mem_model (
    input  wire logic        i_clock,
    input  wire logic        i_rd,
    input  wire logic [11:0] i_addr,
    output logic      [15:0] o_data
);
    // Between reads the word keeps flipping so stale data never matches
    always_ff @(posedge i_clock) begin
        if (i_rd) begin
            o_data <= {i_addr[11:4], i_addr[7:0] ^ 8'ha5};
        end else begin
            o_data <= ~o_data;
        end
    end
endmodule

// ### verification/exec_tail_test.sv
// Self-checking bench for the instruction execute tail
`timescale 1ns/1ns
module exec_tail_test;
    import exec_tail_pkg::*;
    logic        clk = 0;
    logic        rst = 1;
    logic        hsel = 0;
    logic [31:0] haddr = 0;
    logic [1:0]  htrans = 0;
    logic        hwrite = 0;
    logic [31:0] hwdata = 0;
    logic [3:0]  page = 0;
    logic        rdy, hresp, prd, dum, done;
    logic [31:0] hrdata;
    logic [11:0] paddr;
    logic [15:0] pdata;
    int          err_count = 0;
    int          tests_run = 0;
    int          dummies = 0;
    int          dones = 0;

    always #4 clk = ~clk;
    always @(posedge clk) if (dum) dummies <= dummies + 1;
    always @(posedge clk) if (done) dones <= dones + 1;

    exec_tail DUT (.i_clock(clk), .i_reset(rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata),
        .i_hready(rdy), .o_hreadyout(rdy), .o_hresp(hresp), .o_hrdata(hrdata),
        .i_current_page(page), .o_prog_addr(paddr), .o_prog_rd(prd),
        .i_prog_data(pdata), .o_dummy_cycle(dum), .o_instr_done(done));
    prog_mem_model pmem (.i_clock(clk), .i_rd(prd), .i_addr(paddr), .o_data(pdata));

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        tests_run++;
        if (got !== want) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    // Ready is looked at on the falling edge, half a cycle before the rising edge, where it can no longer move
    task automatic wait_rdy(output logic [31:0] d);
        do @(negedge clk); while (rdy !== 1'b1);
        d = hrdata;
        @(posedge clk);
    endtask

    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] wd,
                        output logic [31:0] d);
        hsel <= 1;
        haddr <= {20'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        wait_rdy(d);
        hsel <= 0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy(d);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] wd);
        logic [31:0] d;
        xfer(a, 1'b1, wd, d);
    endtask

    // Returns skip, flags, accumulator and memory byte
    function automatic logic [21:0] model(int op, logic [7:0] a, m, imm,
                                          logic [4:0] f, logic [2:0] b);
        logic [8:0] s;
        logic [7:0] ac, mm, r;
        logic [4:0] fl;
        logic       sk, cin;
        int         zd;
        ac = a;
        mm = m;
        fl = f;
        sk = 0;
        r = 0;
        zd = 0;
        if (op inside {9, 12, 14, 16, 19, 22, 24}) zd = 2;
        else if (op inside {8, 10, 11, 13, 15, 20, 23, 25}) zd = 1;
        case (op)
            0: ac = {m[3:0], m[7:4]};
            1: sk = (m == 0);
            2: begin
                ac = m;
                sk = (m == 0);
            end
            3: sk = !m[b];
            8, 9: r = a ^ m;
            10: r = a ^ imm;
            11, 12, 13, 14: begin
                cin = (op < 13) & f[0];
                s = a + m + cin;
                r = s[7:0];
                fl[0] = s[8];
                fl[1] = (a[3:0] + m[3:0] + cin) > 15;
                fl[3] = (a[7] == m[7]) && (r[7] != a[7]);
                fl[4] = fl[3] ^ r[7];
            end
            15, 16: r = a & m;
            17: mm = 8'h00;
            18: mm[b] = 1'b0;
            19, 20: r = ~m;
            21: begin
                s = {1'b0, a};
                if (a[3:0] > 4'h9 || f[1]) s = s + 9'h06;
                if (s[7:4] > 4'h9 || f[0] || s[8]) s = s + 9'h60;
                fl[0] = f[0] | s[8];
                mm = s[7:0];
            end
            22, 23: r = m - 1;
            24, 25: r = m + 1;
            26: ac = m;
            27: mm = a;
            default: ;
        endcase
        if (zd != 0) fl[2] = (r == 0);
        if (zd == 2) mm = r;
        if (zd == 1) ac = r;
        return {sk, fl, ac, mm};
    endfunction

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #400000;
        err_count++;
        final_report();
    end

    initial begin
        logic [31:0] v;
        logic [21:0] e;
        logic [7:0]  a, m, imm, tl, th, p;
        logic [4:0]  f;
        logic [2:0]  b;
        logic        bk;
        int          d0, d1;
        logic [8:0]  n;
        logic [11:0] mem, pa;
        int          op;
        void'($urandom(60));
        repeat (6) @(posedge clk);
        rst <= 0;
        xfer(OFF_FLAGS, 1'b0, 0, v);
        chk(v[4:0], 0);
        chk(hresp, 0);
        wr(12'h020, 32'hffff_ffff);
        xfer(12'h020, 1'b0, 0, v);
        chk(v, 0);
        $display("test reset and unmapped done");
        for (int i = 0; i < 96; i++) begin
            op = (i % 24 < 4) ? i % 24 : i % 24 + 4;
            a = 8'($urandom);
            m = (i < 24) ? 8'h00 : (i < 48) ? 8'hff : 8'($urandom);
            imm = 8'($urandom);
            f = 5'($urandom);
            b = 3'($urandom);
            n = 9'($urandom_range(511, 0));
            bk = 1'($urandom);
            // Plain forms see only the selected section, extended ones the full address
            mem = {1'b1, (op > 10) ? n : {bk, n[7:0]}, 2'b00};
            wr(OFF_BANK, {31'h0, bk});
            wr(mem, {24'h0, m});
            wr(OFF_ACC, {24'h0, a});
            wr(OFF_FLAGS, {27'h0, f});
            wr(OFF_ADDR, {23'h0, n});
            d0 = dummies;
            d1 = dones;
            wr(OFF_CMD, {8'h0, imm, 5'h0, b, 3'h0, op[4:0]});
            e = model(op, a, m, imm, f, b);
            xfer(OFF_ACC, 1'b0, 0, v);
            chk(v, {24'h0, e[15:8]});
            xfer(OFF_FLAGS, 1'b0, 0, v);
            chk(v[4:0], e[20:16]);
            if (op < 4) chk(v[9], e[21]);
            chk(dummies - d0, e[21]);
            chk(dones - d1, 1);
            xfer(mem, 1'b0, 0, v);
            chk(v, {24'h0, e[7:0]});
        end
        $display("test alu and skips done");
        for (int i = 0; i < 16; i++) begin
            op = 4 + i % 4;
            tl = (i < 4) ? 8'hff : 8'($urandom);
            th = 8'($urandom);
            f = 5'($urandom);
            n = 9'($urandom_range(255, 0));
            mem = {1'b1, bk, n[7:0], 2'b00};
            @(posedge clk);
            page <= 4'($urandom);
            wr(OFF_TBL_LOW, {24'h0, tl});
            wr(OFF_TBL_HIGH, {24'h0, th});
            wr(OFF_ADDR, {23'h0, n});
            wr(OFF_FLAGS, {27'h0, f});
            d1 = dones;
            wr(OFF_CMD, {27'h0, op[4:0]});
            p = tl + 8'(op > 5);
            pa = (op == 4) ? {page, p} : (op == 6) ? {th[3:0], p} : {4'hf, p};
            xfer(mem, 1'b0, 0, v);
            chk(v, {24'h0, pa[7:0] ^ 8'ha5});
            xfer(OFF_TBL_BYTE, 1'b0, 0, v);
            chk(v, {24'h0, pa[11:4]});
            xfer(OFF_TBL_LOW, 1'b0, 0, v);
            chk(v, {24'h0, p});
            xfer(OFF_FLAGS, 1'b0, 0, v);
            chk(v[4:0], f);
            chk(dones - d1, 1);
        end
        $display("test table reads done");
        final_report();
    end
endmodule
